// [dv/tb_crystal_fail_detect.sv]
// self-checking bench for the crystal failure detector with a reference model
`timescale 1ns/1ps
`default_nettype none

module tb_crystal_fail_detect;
   localparam int RC_CYC = 200;
   logic        clk    = 1'b0;
   logic        rst_n  = 1'b0;
   logic [7:0]  addr   = 8'h00;
   logic [31:0] wdata  = 32'h0000_0000;
   logic        wr     = 1'b0;
   logic        rd     = 1'b0;
   logic        run    = 1'b1;
   logic        slow   = 1'b0;
   logic [31:0] rdata;
   logic        irq, fault, rc_en, xtal_en, mrc_en, src_xtal, xtal_clk, rc_clk;
   logic [1:0]  system_master_clock;
   int          n_fail = 0;
   int          n_compared = 0;
   int          seed = 32'h01cd_2709;
   int          cfg_m, css_m, ev_m, fos_m, live_m, ie_m;

   always #20 clk = ~clk;

   crystal_fail_detect crystal_fail_detect_i (
      .CLK_SYS_IN(clk), .RESET_N_IN(rst_n), .XTAL_CLK_IN(xtal_clk),
      .SLOW_RC_CLK_IN(rc_clk), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr),
      .RD_IN(rd), .RDATA_OUT(rdata), .IRQ_OUT(irq), .FAULT_OUT(fault),
      .SLOW_RC_ENABLE_OUT(rc_en), .CRYSTAL_OSC_ENABLE_OUT(xtal_en),
      .MAIN_RC_ENABLE_OUT(mrc_en), .MAIN_CLK_SRC_XTAL_OUT(src_xtal),
      .MCK_SRC_SEL_OUT(system_master_clock));

   // the crystal only oscillates while its enable output is set
   xtal_rc_model xtal_rc_model_i (
      .rc_enable_in(rc_en), .xtal_run_in(run & xtal_en), .xtal_slow_in(slow),
      .xtal_clk_out(xtal_clk), .rc_clk_out(rc_clk));

   function automatic logic [31:0] exp_rd(logic [7:0] a);
      case (a)
         cfd_pkg::OFS_MAIN_OSC_CFG: return 32'(cfg_m);
         cfd_pkg::OFS_MCK_CFG:      return 32'(css_m);
         cfd_pkg::OFS_STATUS:       return 32'(live_m * 4 + fos_m * 2 + ev_m);
         cfd_pkg::OFS_INT_ENABLE:   return 32'(ie_m);
         default:                   return 32'h0000_0000;
      endcase
   endfunction

   function automatic logic [7:0] exp_pins();
      return {1'(ev_m & ie_m), 1'(fos_m), 1'(cfg_m >> 1), 1'(cfg_m),
              1'(cfg_m >> 3), 1'(cfg_m >> 2), 2'(css_m)};
   endfunction

   task automatic chk_rd(logic [31:0] got, logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: read %h, expected %h", $time, got, exp);
      end
   endtask

   // outputs are registered, so let the launching edge and one more pass
   task automatic chk_pins();
      logic [7:0] got;
      repeat (2) @(posedge clk);
      #1;
      got = {irq, fault, rc_en, xtal_en, mrc_en, src_xtal, system_master_clock};
      n_compared++;
      if (got !== exp_pins()) begin
         n_fail++;
         $display("Error at %0t: pins %b, expected %b", $time, got, exp_pins());
      end
   endtask

   task automatic wr_reg(logic [7:0] a, logic [31:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
      case (a)
         cfd_pkg::OFS_MAIN_OSC_CFG: cfg_m = d[3:0];
         cfd_pkg::OFS_MCK_CFG:      css_m = d[1:0];
         cfd_pkg::OFS_STATUS:       if (d[0]) ev_m = 0;
         cfd_pkg::OFS_INT_ENABLE:   ie_m = d[0];
         cfd_pkg::OFS_FAULT_CLEAR:  if (d[0]) fos_m = 0;
         default: ;
      endcase
      if (cfg_m[1:0] != 2'b11) live_m = 0;
   endtask

   task automatic rd_reg(logic [7:0] a);
      logic [31:0] e;
      e = exp_rd(a);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk_rd(rdata, e);
      if (a == cfd_pkg::OFS_STATUS) ev_m = 0;
   endtask

   task automatic close_out();
      $display("compared %0d, mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial begin
      int k, n, lim, r;
      cfg_m = 8;
      css_m = 1;
      ev_m = 0;
      fos_m = 0;
      live_m = 0;
      ie_m = 0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      chk_pins();
      for (k = 0; k < 24; k += 4) rd_reg(8'(k));
      $display("test reset done");
      for (k = 0; k < 3; k++) begin
         run <= 1'b1;
         slow <= 1'b0;
         r = $random(seed);
         wr_reg(cfd_pkg::OFS_MCK_CFG, 32'(k + 1));
         wr_reg(cfd_pkg::OFS_INT_ENABLE, r);
         wr_reg(cfd_pkg::OFS_MAIN_OSC_CFG, 32'(3 | (r & 12) | (k == 1 ? 4 : 0)));
         repeat (2 * RC_CYC + 50) @(posedge clk);
         rd_reg(cfd_pkg::OFS_STATUS);
         chk_pins();
         // slow crystal gives six or seven edges per window, one or two short of a pass
         if (k == 0) slow <= 1'b1;
         else run <= 1'b0;
         lim = (k == 0 ? 2 : 3) * RC_CYC + 20;
         for (n = 0; n < lim && fault !== 1'b1; n++) begin
            @(posedge clk);
            #1;
         end
         if (n == lim) begin
            n_fail++;
            $display("Error at %0t: no failure reported", $time);
         end
         ev_m = 1;
         fos_m = 1;
         live_m = 1;
         if (cfg_m[2] && css_m >= 2) css_m = 1;
         cfg_m = (cfg_m & 3) | 8;
         chk_pins();
         // the last pass clears the event by a write of one instead of a read
         if (k == 2) wr_reg(cfd_pkg::OFS_STATUS, 32'h0000_0001);
         rd_reg(cfd_pkg::OFS_STATUS);
         rd_reg(cfd_pkg::OFS_STATUS);
         rd_reg(cfd_pkg::OFS_MAIN_OSC_CFG);
         rd_reg(cfd_pkg::OFS_MCK_CFG);
         wr_reg(cfd_pkg::OFS_MAIN_OSC_CFG, 32'(cfg_m & (k == 1 ? 14 : 13)));
         repeat (2 * RC_CYC + 50) @(posedge clk);
         rd_reg(cfd_pkg::OFS_STATUS);
         chk_pins();
         wr_reg(cfd_pkg::OFS_FAULT_CLEAR, 32'h0000_0001);
         rd_reg(cfd_pkg::OFS_STATUS);
         chk_pins();
         $display("test %0d done", k);
      end
      close_out();
   end

   initial begin
      repeat (12000) @(posedge clk);
      n_fail++;
      $display("Error at %0t: watchdog expired", $time);
      close_out();
   end
endmodule
`default_nettype wire

// [dv/xtal_rc_model.sv]
// behavioural crystal and slow RC oscillators facing the failure detector
`timescale 1ns/1ps
`default_nettype none

module xtal_rc_model #(
   parameter int XTAL_HALF = 117,
   parameter int SLOW_HALF = 290,
   parameter int RC_HALF   = 4000
) (
   input  wire logic rc_enable_in,
   input  wire logic xtal_run_in,
   input  wire logic xtal_slow_in,
   output logic      xtal_clk_out,
   output logic      rc_clk_out
);
   // a stopped oscillator rests low rather than freezing at its last level
   initial begin
      xtal_clk_out = 1'b0;
      forever begin
         if (xtal_run_in) begin
            #(xtal_slow_in ? SLOW_HALF : XTAL_HALF);
            xtal_clk_out = xtal_run_in & ~xtal_clk_out;
         end else begin
            xtal_clk_out = 1'b0;
            #13;
         end
      end
   end

   // slow RC runs only while the detector enable asks for it
   initial begin
      rc_clk_out = 1'b0;
      forever begin
         if (rc_enable_in) begin
            #(RC_HALF);
            rc_clk_out = rc_enable_in & ~rc_clk_out;
         end else begin
            rc_clk_out = 1'b0;
            #13;
         end
      end
   end
endmodule
`default_nettype wire

// [hw/cfd_pin_sync.sv]
// two-flop synchroniser with edge pulses for clock pins sampled on the system clock
`timescale 1ns/1ps
`default_nettype none

module cfd_pin_sync #(
   parameter int unsigned WIDTH = 2
) (
   input  wire logic             clk_in,
   input  wire logic             reset_n_in,
   input  wire logic [WIDTH-1:0] pin_in,
   output logic      [WIDTH-1:0] level_out,
   output logic      [WIDTH-1:0] rise_out,
   output logic      [WIDTH-1:0] fall_out
);

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] sync;
      logic [WIDTH-1:0] prev;
   } sync_state_t;

   sync_state_t s_q;
   sync_state_t s_d;

   initial begin
      if (WIDTH < 1) begin
         $error("cfd_pin_sync: WIDTH must be at least 1");
      end
   end

   // meta is read only by sync; edges come from sync and prev
   always_comb begin
      s_d      = s_q;
      s_d.meta = pin_in;
      s_d.sync = s_q.meta;
      s_d.prev = s_q.sync;
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign level_out = s_q.sync;
   assign rise_out  = s_q.sync & ~s_q.prev;
   assign fall_out  = ~s_q.sync & s_q.prev;

endmodule

`default_nettype wire

// [hw/cfd_pkg.sv]
// constants and types for the crystal oscillator failure detector
package cfd_pkg;

   localparam int unsigned ADDR_W   = 8;
   localparam int unsigned DATA_W   = 32;
   localparam int unsigned CNT_W    = 4;
   localparam int unsigned FAIL_MIN = 8;

   // register offsets
   localparam logic [7:0] OFS_MAIN_OSC_CFG  = 8'h00;
   localparam logic [7:0] OFS_MCK_CFG       = 8'h04;
   localparam logic [7:0] OFS_STATUS        = 8'h08;
   localparam logic [7:0] OFS_INT_ENABLE    = 8'h0C;
   localparam logic [7:0] OFS_FAULT_CLEAR   = 8'h10;

   // main oscillator configuration fields
   localparam int unsigned BIT_XTAL_EN   = 0;
   localparam int unsigned BIT_FDE       = 1;
   localparam int unsigned BIT_XSEL      = 2;
   localparam int unsigned BIT_MAIN_RC   = 3;
   // master clock configuration field
   localparam int unsigned BIT_CSS_LO    = 0;
   // status fields, interrupt enable holds only the event bit position
   localparam int unsigned BIT_EVENT     = 0;
   localparam int unsigned BIT_FOS       = 1;
   localparam int unsigned BIT_LIVE      = 2;
   // fault clear field
   localparam int unsigned BIT_FAULT_CLEAR_BIT     = 0;

   // master clock source encodings
   localparam logic [1:0] CSS_SLOW  = 2'h0;
   localparam logic [1:0] CSS_MAIN  = 2'h1;
   localparam logic [1:0] CSS_PLLA  = 2'h2;
   localparam logic [1:0] CSS_UPLL  = 2'h3;

   typedef enum logic [1:0] {
      DET_IDLE,
      DET_ARM,
      DET_RUN
   } det_state_t;

   typedef struct packed {
      logic       crystal_osc_enable;
      logic       fail_detect_enable;
      logic       crystal_select_bit;
      logic       main_rc_enable;
      logic [1:0] master_clock_source_select;
   } osc_cfg_t;

   typedef struct packed {
      osc_cfg_t          cfg;
      det_state_t        det;
      logic [CNT_W-1:0]  cnt;
      logic              fail;
      logic              clock_fail_event_flag;
      logic              fault_output_status;
      logic              clock_fail_live_status;
      logic              int_enable;
      logic              irq;
      logic [DATA_W-1:0] rdata;
   } cfd_state_t;

   localparam osc_cfg_t CFG_RESET = '{
      crystal_osc_enable:         1'b0,
      fail_detect_enable:         1'b0,
      crystal_select_bit:         1'b0,
      main_rc_enable:             1'b1,
      master_clock_source_select: CSS_MAIN
   };

   localparam logic [CNT_W-1:0]  CNT_ZERO   = 4'h0;
   localparam logic [DATA_W-1:0] DATA_ZERO  = 32'h0000_0000;

endpackage

// [hw/crystal_fail_detect.sv]
// crystal oscillator failure detector with register port and clock switchover
//
// Function
// - detector runs only with its enable bit set; reset clears that bit.
// - detector is off whenever the crystal oscillator enable bit is zero.
// - setting the detector enable also turns on the slow RC oscillator.
// - crystal edge counter held at zero while slow RC low, counts while high.
// - fewer than eight crystal edges in one slow RC high phase is a failure.
// - after enabling, a failure may take up to two slow RC cycles to show.
// - a failure sets both the event flag and the fault output status flag.
// - any read of the status register clears the event flag.
// - fault output status stays set until software writes one to fault clear.
// - only the event flag interrupts, and only when its enable bit is set.
// - a live failure status bit can be read at any time.
// - crystal selected and master clock on a PLL: failure forces main clock.
// - any failure forces the main RC oscillator as main clock source.
// - a disabled main RC oscillator is re-enabled by a failure.
// - switchover ends within two slow RC cycles, three from a PLL.
// - a failure asserts the fault output toward the PWM controller.
`timescale 1ns/1ps
`default_nettype none

module crystal_fail_detect #(
   parameter int unsigned MIN_COUNT = cfd_pkg::FAIL_MIN
) (
   input  wire logic                       CLK_SYS_IN,
   input  wire logic                       RESET_N_IN,
   input  wire logic                       XTAL_CLK_IN,
   input  wire logic                       SLOW_RC_CLK_IN,
   input  wire logic [cfd_pkg::ADDR_W-1:0] ADDR_IN,
   input  wire logic [cfd_pkg::DATA_W-1:0] WDATA_IN,
   input  wire logic                       WR_IN,
   input  wire logic                       RD_IN,
   output logic      [cfd_pkg::DATA_W-1:0] RDATA_OUT,
   output logic                            IRQ_OUT,
   output logic                            FAULT_OUT,
   output logic                            SLOW_RC_ENABLE_OUT,
   output logic                            CRYSTAL_OSC_ENABLE_OUT,
   output logic                            MAIN_RC_ENABLE_OUT,
   output logic                            MAIN_CLK_SRC_XTAL_OUT,
   output logic      [1:0]                 MCK_SRC_SEL_OUT
);

   cfd_pkg::cfd_state_t s_q;
   cfd_pkg::cfd_state_t s_d;

   logic [1:0] pin_level;
   logic [1:0] pin_rise;
   logic [1:0] pin_fall;
   logic       xtal_rise;
   logic       rc_level;
   logic       rc_fall;
   logic       active;
   logic       short_count;
   logic       wr_cfg;
   logic       wr_mck;
   logic       wr_status;
   logic       wr_ie;
   logic       wr_fault_clear_bit;
   logic       rd_status;

   initial begin
      if (MIN_COUNT < 1 || MIN_COUNT > 15) begin
         $error("crystal_fail_detect: MIN_COUNT must lie in 1..15");
      end
   end

   // both clocks are foreign to the system clock, so both pass two flops;
   // the crystal must run below half the system clock or edges are missed
   cfd_pin_sync #(
      .WIDTH (2)
   ) u_pin_sync (
      .clk_in     (CLK_SYS_IN),
      .reset_n_in (RESET_N_IN),
      .pin_in     ({SLOW_RC_CLK_IN, XTAL_CLK_IN}),
      .level_out  (pin_level),
      .rise_out   (pin_rise),
      .fall_out   (pin_fall)
   );

   assign xtal_rise = pin_rise[0];
   assign rc_level  = pin_level[1];
   assign rc_fall   = pin_fall[1];

   assign active      = s_q.cfg.fail_detect_enable & s_q.cfg.crystal_osc_enable;
   assign short_count = (s_q.cnt < MIN_COUNT[cfd_pkg::CNT_W-1:0]);

   assign wr_cfg    = WR_IN && (ADDR_IN == cfd_pkg::OFS_MAIN_OSC_CFG);
   assign wr_mck    = WR_IN && (ADDR_IN == cfd_pkg::OFS_MCK_CFG);
   assign wr_status = WR_IN && (ADDR_IN == cfd_pkg::OFS_STATUS);
   assign wr_ie     = WR_IN && (ADDR_IN == cfd_pkg::OFS_INT_ENABLE);
   assign wr_fault_clear_bit  = WR_IN && (ADDR_IN == cfd_pkg::OFS_FAULT_CLEAR);
   assign rd_status = RD_IN && (ADDR_IN == cfd_pkg::OFS_STATUS);

   always_comb begin
      s_d      = s_q;
      s_d.fail = 1'b0;

      // register writes
      if (wr_cfg) begin
         s_d.cfg.crystal_osc_enable = WDATA_IN[cfd_pkg::BIT_XTAL_EN];
         s_d.cfg.fail_detect_enable = WDATA_IN[cfd_pkg::BIT_FDE];
         s_d.cfg.crystal_select_bit = WDATA_IN[cfd_pkg::BIT_XSEL];
         s_d.cfg.main_rc_enable     = WDATA_IN[cfd_pkg::BIT_MAIN_RC];
      end
      if (wr_mck) begin
         s_d.cfg.master_clock_source_select = WDATA_IN[cfd_pkg::BIT_CSS_LO +: 2];
      end
      if (wr_ie) begin
         s_d.int_enable = WDATA_IN[cfd_pkg::BIT_EVENT];
      end

      // detector; a partial high phase right after enabling is never judged
      if (!active) begin
         s_d.det                    = cfd_pkg::DET_IDLE;
         s_d.cnt                    = cfd_pkg::CNT_ZERO;
         s_d.clock_fail_live_status = 1'b0;
      end else begin
         unique case (s_q.det)
            cfd_pkg::DET_IDLE: begin
               s_d.det = cfd_pkg::DET_ARM;
            end
            cfd_pkg::DET_ARM: begin
               if (!rc_level) begin
                  s_d.det = cfd_pkg::DET_RUN;
               end
               s_d.cnt = cfd_pkg::CNT_ZERO;
            end
            cfd_pkg::DET_RUN: begin
               if (rc_fall) begin
                  // result taken from synchronised samples only
                  s_d.fail                   = short_count;
                  s_d.clock_fail_live_status = short_count;
                  s_d.cnt                    = cfd_pkg::CNT_ZERO;
               end else if (!rc_level) begin
                  s_d.cnt = cfd_pkg::CNT_ZERO;
               end else if (xtal_rise && short_count) begin
                  // saturate once the threshold is met
                  s_d.cnt = s_q.cnt + 4'h1;
               end
            end
            default: begin
               s_d.det = cfd_pkg::DET_IDLE;
            end
         endcase
      end

      // flags: a clear never hides a failure in the same cycle
      if (rd_status || (wr_status && WDATA_IN[cfd_pkg::BIT_EVENT])) begin
         s_d.clock_fail_event_flag = 1'b0;
      end
      if (wr_fault_clear_bit && WDATA_IN[cfd_pkg::BIT_FAULT_CLEAR_BIT]) begin
         s_d.fault_output_status = 1'b0;
      end
      if (s_q.fail) begin
         s_d.clock_fail_event_flag = 1'b1;
         s_d.fault_output_status   = 1'b1;
         if (s_q.cfg.crystal_select_bit && s_q.cfg.master_clock_source_select[1]) begin
            s_d.cfg.master_clock_source_select = cfd_pkg::CSS_MAIN;
         end
         s_d.cfg.crystal_select_bit = 1'b0;
         s_d.cfg.main_rc_enable     = 1'b1;
      end

      s_d.irq = s_d.clock_fail_event_flag & s_d.int_enable;

      // read data stands for exactly the cycle after the strobe
      s_d.rdata = cfd_pkg::DATA_ZERO;
      if (RD_IN) begin
         unique case (ADDR_IN)
            cfd_pkg::OFS_MAIN_OSC_CFG: begin
               s_d.rdata[cfd_pkg::BIT_XTAL_EN] = s_q.cfg.crystal_osc_enable;
               s_d.rdata[cfd_pkg::BIT_FDE]     = s_q.cfg.fail_detect_enable;
               s_d.rdata[cfd_pkg::BIT_XSEL]    = s_q.cfg.crystal_select_bit;
               s_d.rdata[cfd_pkg::BIT_MAIN_RC] = s_q.cfg.main_rc_enable;
            end
            cfd_pkg::OFS_MCK_CFG: begin
               s_d.rdata[cfd_pkg::BIT_CSS_LO +: 2] = s_q.cfg.master_clock_source_select;
            end
            cfd_pkg::OFS_STATUS: begin
               s_d.rdata[cfd_pkg::BIT_EVENT] = s_q.clock_fail_event_flag;
               s_d.rdata[cfd_pkg::BIT_FOS]   = s_q.fault_output_status;
               s_d.rdata[cfd_pkg::BIT_LIVE]  = s_q.clock_fail_live_status;
            end
            cfd_pkg::OFS_INT_ENABLE: begin
               s_d.rdata[cfd_pkg::BIT_EVENT] = s_q.int_enable;
            end
            default: begin
               s_d.rdata = cfd_pkg::DATA_ZERO;
            end
         endcase
      end
   end

   always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         s_q                        <= '0;
         s_q.cfg                    <= cfd_pkg::CFG_RESET;
         s_q.det                    <= cfd_pkg::DET_IDLE;
         s_q.cnt                    <= cfd_pkg::CNT_ZERO;
         s_q.rdata                  <= cfd_pkg::DATA_ZERO;
      end else begin
         s_q <= s_d;
      end
   end

   assign RDATA_OUT              = s_q.rdata;
   assign IRQ_OUT                = s_q.irq;
   assign FAULT_OUT              = s_q.fault_output_status;
   assign SLOW_RC_ENABLE_OUT     = s_q.cfg.fail_detect_enable;
   assign CRYSTAL_OSC_ENABLE_OUT = s_q.cfg.crystal_osc_enable;
   assign MAIN_RC_ENABLE_OUT     = s_q.cfg.main_rc_enable;
   assign MAIN_CLK_SRC_XTAL_OUT  = s_q.cfg.crystal_select_bit;
   assign MCK_SRC_SEL_OUT        = s_q.cfg.master_clock_source_select;

   // checks
   default clocking cb @(posedge CLK_SYS_IN);
   endclocking
   default disable iff (!RESET_N_IN);

   sequence seq_fail_seen;
      s_q.fail;
   endsequence

   sequence seq_switched;
      MAIN_RC_ENABLE_OUT && !MAIN_CLK_SRC_XTAL_OUT;
   endsequence

   sequence seq_window_short;
      (s_q.det == cfd_pkg::DET_RUN) && active && rc_fall && short_count;
   endsequence

   AST_OFF_NO_FAIL: assert property (!active |=> !s_q.fail)
      else $error("failure reported while detector inactive");

   AST_RC_FOLLOWS_ENABLE: assert property (
      $rose(s_q.cfg.fail_detect_enable) |-> SLOW_RC_ENABLE_OUT)
      else $error("slow rc not enabled with detector");

   AST_COUNT_HELD_LOW: assert property (
      active && (s_q.det == cfd_pkg::DET_RUN) && !rc_level && !rc_fall |=> s_q.cnt == 4'h0)
      else $error("counter not held while slow rc low");

   AST_SHORT_WINDOW_FAILS: assert property (seq_window_short |=> seq_fail_seen)
      else $error("short window did not report failure");

   AST_FLAGS_ON_FAIL: assert property (
      seq_fail_seen |=> s_q.clock_fail_event_flag && FAULT_OUT)
      else $error("failure did not set both flags");

   AST_READ_CLEARS_EVENT: assert property (
      rd_status && !s_q.fail |=> !s_q.clock_fail_event_flag)
      else $error("status read left event flag set");

   AST_FAULT_STICKY: assert property (
      FAULT_OUT && !(wr_fault_clear_bit && WDATA_IN[cfd_pkg::BIT_FAULT_CLEAR_BIT]) |=> FAULT_OUT)
      else $error("fault output dropped without clear");

   AST_FAULT_CLEAR: assert property (
      wr_fault_clear_bit && WDATA_IN[cfd_pkg::BIT_FAULT_CLEAR_BIT] && !s_q.fail |=> !FAULT_OUT)
      else $error("fault clear ignored");

   AST_IRQ_GATED: assert property (
      ##1 IRQ_OUT == (s_q.clock_fail_event_flag && s_q.int_enable))
      else $error("interrupt does not match enabled event flag");

   AST_SWITCH_TO_RC: assert property (seq_fail_seen |=> seq_switched)
      else $error("failure did not switch to main rc");

   AST_PLL_FALLBACK: assert property (
      seq_fail_seen and (s_q.cfg.crystal_select_bit && s_q.cfg.master_clock_source_select[1])
      |=> MCK_SRC_SEL_OUT == cfd_pkg::CSS_MAIN)
      else $error("master clock not returned to main clock");

   AST_LIVE_ON_FAIL: assert property (seq_fail_seen |-> s_q.clock_fail_live_status)
      else $error("live status not set on failure");

endmodule

`default_nettype wire
